// ---- src/urf_pkg.sv ----
// constants and types shared by the user register file and its storage
package urf_pkg;

   localparam int GPR_W    = 32;
   localparam int FPR_W    = 64;
   localparam int REG_CNT  = 32;
   localparam int ADDR_W   = 5;
   localparam int GPR_RD   = 2;
   localparam int FPR_RD   = 3;
   localparam int FLD_CNT  = 8;
   localparam int FLD_W    = 4;

   // status register bit positions, bit 0 is the most significant
   localparam int B_FX  = 0;
   localparam int B_FEX = 1;
   localparam int B_VX  = 2;
   localparam int B_OX  = 3;
   localparam int B_UX  = 4;
   localparam int B_ZX  = 5;
   localparam int B_XX  = 6;
   localparam int B_VE  = 24;
   localparam int B_OE  = 25;
   localparam int B_UE  = 26;
   localparam int B_ZE  = 27;
   localparam int B_XE  = 28;

   localparam logic [0:31] STICKY_MASK  = 32'h9FF80700;
   localparam logic [0:31] EXC_MASK     = 32'h1FF80700;
   localparam logic [0:31] VX_MASK      = 32'h01F80700;
   localparam logic [0:31] SUMMARY_MASK = 32'h60000000;
   localparam logic [0:31] NONSTK_MASK  = 32'h0007F000;
   localparam logic [0:31] FPCC_MASK    = 32'h0000F000;
   localparam logic [0:31] RESV_MASK    = 32'h00000800;
   localparam logic [0:31] STATUS_MASK  = 32'hFFFFFF00;
   localparam logic [0:31] CTRL_MASK    = 32'h000000FF;
   localparam logic [0:31] FX_MASK      = 32'h80000000;
   localparam logic [0:31] FLD0_MASK    = 32'hF0000000;

   // single to double conversion
   localparam logic [10:0] SP_TO_DP_BIAS = 11'h380;
   localparam logic [7:0]  SP_EXP_MAX    = 8'hFF;
   localparam logic [10:0] DP_EXP_MAX    = 11'h7FF;

   localparam logic [2:0] CR_FLD_RST  = 3'h0;
   localparam logic [3:0] CR_DATA_RST = 4'h0;

   typedef enum logic [2:0] {
      URF_OP_NONE  = 3'b000,
      URF_OP_FIELD = 3'b001,
      URF_OP_IMM   = 3'b011,
      URF_OP_CLR   = 3'b010,
      URF_OP_SET   = 3'b110,
      URF_OP_COPY  = 3'b111
   } urf_fs_op_t;

endpackage : urf_pkg

// ---- src/urf_mem_if.sv ----
// carrier between the register file top and its storage arrays
`timescale 1ns/1ns
interface urf_mem_if #(
   parameter int W  = 32,
   parameter int NR = 2,
   parameter int AW = 5
);
   logic          we;
   logic [AW-1:0] wa;
   logic [W-1:0]  wd;
   logic [AW-1:0] ra [NR];
   logic [W-1:0]  rd [NR];

   modport owner (output we, output wa, output wd, output ra, input rd);
   modport store (input we, input wa, input wd, input ra, output rd);
endinterface : urf_mem_if

// ---- src/urf_mem.sv ----
// thirty-two entry register array, one write port, registered read ports
`timescale 1ns/1ns
module urf_mem
   import urf_pkg::*;
#(
   parameter int W  = 32,
   parameter int NR = 2,
   parameter int AW = 5
) (
   input wire logic  i_mclk,
   urf_mem_if.store  bus
);
   logic [W-1:0] cells [REG_CNT];

   // no reset on purpose: contents survive a reset
   always_ff @(posedge i_mclk) begin
      if (bus.we) begin
         cells[bus.wa] <= bus.wd;
      end
   end

   // read during write of the same entry returns the old value
   for (genvar g = 0; g < NR; g++) begin : g_rd
      always_ff @(posedge i_mclk) begin
         bus.rd[g] <= cells[bus.ra[g]];
      end
   end

endmodule : urf_mem

// ---- src/urf_user_regs.sv ----
// user register set: general and floating registers, float status/control
//
// Summary of operation
// - thirty-two general registers of 32 bits hold all integer data.
// - general registers are chosen only by instruction operand fields.
// - thirty-two floating registers of 64 bits, chosen by operand fields.
// - floating registers always hold double format, singles are widened.
// - arithmetic results go to floating registers, compares to condition fields.
// - operation status lands in status/condition only at writeback.
// - status bits 0..23 are status, bits 24..31 are control.
// - bits 0..12 and 21..23 sticky except summaries 1,2; 13..20 not.
// - sticky bits stay set until a field move, immediate, copy or clear.
// - both summaries are ORs and are never written directly.
// - a new zero-to-one exception flag also sets the exception summary.
// - enabled summary is OR of each flag ANDed with its enable.
// - invalid summary is OR of all invalid-operation flags.
// - reserved bits ignore writes and read as zero.
`timescale 1ns/1ns
module urf_user_regs
   import urf_pkg::*;
(
   input  wire logic               i_mclk,
   input  wire logic               i_rst,
   input  wire logic [ADDR_W-1:0]  i_gpr_src [GPR_RD],
   input  wire logic               i_gpr_we,
   input  wire logic [ADDR_W-1:0]  i_gpr_dst,
   input  wire logic [GPR_W-1:0]   i_gpr_wdata,
   output logic      [GPR_W-1:0]   o_gpr_rdata [GPR_RD],
   input  wire logic [ADDR_W-1:0]  i_fpr_src [FPR_RD],
   input  wire logic               i_fpr_we,
   input  wire logic [ADDR_W-1:0]  i_fpr_dst,
   input  wire logic               i_fpr_single,
   input  wire logic [FPR_W-1:0]   i_fpr_wdata,
   output logic      [FPR_W-1:0]   o_fpr_rdata [FPR_RD],
   input  wire logic               i_wb_valid,
   input  wire logic               i_wb_cmp,
   input  wire logic [0:31]        i_wb_exc,
   input  wire logic               i_wb_fr,
   input  wire logic               i_wb_fi,
   input  wire logic [0:4]         i_wb_fprf,
   input  wire logic [2:0]         i_wb_crfld,
   input  wire logic [0:3]         i_wb_cc,
   input  wire urf_fs_op_t         i_fs_op,
   input  wire logic [2:0]         i_fs_fld,
   input  wire logic [0:7]         i_fs_mask,
   input  wire logic [0:31]        i_fs_data,
   input  wire logic [0:3]         i_fs_imm,
   input  wire logic [4:0]         i_fs_bit,
   output logic      [0:31]        o_float_status_control,
   output logic                    o_cr_we,
   output logic      [2:0]         o_cr_fld,
   output logic      [0:3]         o_cr_data
);

   urf_mem_if #(.W(GPR_W), .NR(GPR_RD), .AW(ADDR_W)) gpr_bus ();
   urf_mem_if #(.W(FPR_W), .NR(FPR_RD), .AW(ADDR_W)) fpr_bus ();

   // ---------------- general registers
   assign gpr_bus.we = i_gpr_we;
   assign gpr_bus.wa = i_gpr_dst;
   assign gpr_bus.wd = i_gpr_wdata;
   for (genvar g = 0; g < GPR_RD; g++) begin : g_gpr_port
      assign gpr_bus.ra[g]  = i_gpr_src[g];
      assign o_gpr_rdata[g] = gpr_bus.rd[g];
   end

   urf_mem #(.W(GPR_W), .NR(GPR_RD), .AW(ADDR_W)) u_gpr (
      .i_mclk (i_mclk),
      .bus    (gpr_bus)
   );

   // ---------------- floating registers
   wire        sp_sign = i_fpr_wdata[31];
   wire [7:0]  sp_exp  = i_fpr_wdata[30:23];
   wire [22:0] sp_frac = i_fpr_wdata[22:0];
   wire        sp_zexp = (sp_exp == 8'h00);
   wire        sp_mexp = (sp_exp == SP_EXP_MAX);
   wire [10:0] dp_exp  = sp_zexp ? 11'h000 :
                         sp_mexp ? DP_EXP_MAX :
                         ({3'h0, sp_exp} + SP_TO_DP_BIAS);
   // single denormals flush to signed zero, the assist routine owns them
   wire [22:0] dp_frac = sp_zexp ? 23'h000000 : sp_frac;
   wire [FPR_W-1:0] sp_as_dp = {sp_sign, dp_exp, dp_frac, 29'h00000000};

   assign fpr_bus.we = i_fpr_we;
   assign fpr_bus.wa = i_fpr_dst;
   assign fpr_bus.wd = i_fpr_single ? sp_as_dp : i_fpr_wdata;
   for (genvar g = 0; g < FPR_RD; g++) begin : g_fpr_port
      assign fpr_bus.ra[g]  = i_fpr_src[g];
      assign o_fpr_rdata[g] = fpr_bus.rd[g];
   end

   urf_mem #(.W(FPR_W), .NR(FPR_RD), .AW(ADDR_W)) u_fpr (
      .i_mclk (i_mclk),
      .bus    (fpr_bus)
   );

   // ---------------- float status/control
   logic [0:31] float_status_control;
   logic [0:31] mtf_mask;

   for (genvar g = 0; g < FLD_CNT; g++) begin : g_fld
      assign mtf_mask[g*FLD_W +: FLD_W] = {FLD_W{i_fs_mask[g]}};
   end

   wire [4:0]  fld_sh   = {i_fs_fld, 2'b00};
   wire [0:31] fld_mask = FLD0_MASK >> fld_sh;
   wire [0:31] imm_val  = {i_fs_imm, 28'h0000000} >> fld_sh;
   wire [0:31] bit_mask = FX_MASK >> i_fs_bit;
   wire [0:31] fld_view = float_status_control << fld_sh;

   wire op_field = (i_fs_op == URF_OP_FIELD);
   wire op_imm   = (i_fs_op == URF_OP_IMM);
   wire op_clr   = (i_fs_op == URF_OP_CLR);
   wire op_set   = (i_fs_op == URF_OP_SET);
   wire op_copy  = (i_fs_op == URF_OP_COPY);

   // copy clears only the sticky exception bits of the copied field
   wire [0:31] sw_mask = op_field ? mtf_mask :
                         op_imm   ? fld_mask :
                         (op_clr || op_set) ? bit_mask :
                         op_copy  ? (fld_mask & STICKY_MASK) :
                         32'h00000000;
   wire [0:31] sw_val  = op_field ? i_fs_data :
                         op_imm   ? imm_val :
                         op_set   ? bit_mask :
                         32'h00000000;
   wire [0:31] after_sw = (float_status_control & ~sw_mask) | (sw_val & sw_mask);

   // writeback is applied after software so a same-cycle set wins
   wire [0:31] wb_keep  = i_wb_cmp ? FPCC_MASK : NONSTK_MASK;
   wire [0:31] wb_arith = {13'h0000, i_wb_fr, i_wb_fi, i_wb_fprf, 12'h000};
   wire [0:31] wb_cmpv  = {16'h0000, i_wb_cc, 12'h000};
   wire [0:31] wb_val   = i_wb_cmp ? wb_cmpv : wb_arith;
   wire [0:31] after_wb = i_wb_valid ?
                          ((after_sw & ~wb_keep) | (wb_val & wb_keep)
                           | (i_wb_exc & EXC_MASK)) :
                          after_sw;

   wire        rising   = |(after_wb & ~float_status_control & EXC_MASK);
   wire [0:31] pre      = (after_wb | (rising ? FX_MASK : 32'h00000000))
                          & ~RESV_MASK & ~SUMMARY_MASK;

   wire vx_sum  = |(pre & VX_MASK);
   wire fex_sum = (vx_sum    & pre[B_VE]) | (pre[B_OX] & pre[B_OE]) |
                  (pre[B_UX] & pre[B_UE]) | (pre[B_ZX] & pre[B_ZE]) |
                  (pre[B_XX] & pre[B_XE]);
   wire [0:31] next_float_status_control = pre | {1'b0, fex_sum, vx_sum, 29'h00000000};

   // no reset: the status register keeps its value across reset
   always_ff @(posedge i_mclk) begin
      float_status_control <= next_float_status_control;
   end

   assign o_float_status_control = float_status_control;

   // ---------------- condition field writes
   // a compare writeback wins over a copy in the same cycle
   wire         cmp_wr     = i_wb_valid && i_wb_cmp;
   wire         next_cr_we = cmp_wr || op_copy;
   wire [2:0]   next_cr_fld  = cmp_wr ? i_wb_crfld : i_fs_fld;
   wire [0:3]   next_cr_data = cmp_wr ? i_wb_cc : fld_view[0:3];

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_cr_we   <= 1'b0;
         o_cr_fld  <= CR_FLD_RST;
         o_cr_data <= CR_DATA_RST;
      end else begin
         o_cr_we   <= next_cr_we;
         o_cr_fld  <= next_cr_fld;
         o_cr_data <= next_cr_data;
      end
   end

   // ---------------- assertions
   // status is unknown after power-up until a full field move loads it
   logic status_known;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         status_known <= 1'b0;
      end else if (op_field && i_fs_mask == 8'hFF) begin
         status_known <= 1'b1;
      end
   end

   property p_gpr_rw;
      @(posedge i_mclk) disable iff (i_rst)
      (i_gpr_we ##1 (i_gpr_src[0] == $past(i_gpr_dst) && !i_gpr_we))
      |=> (o_gpr_rdata[0] == $past(i_gpr_wdata, 2));
   endproperty
   a_gpr_rw: assert property (p_gpr_rw) else $error("gpr readback mismatch");

   property p_fpr_single;
      @(posedge i_mclk) disable iff (i_rst)
      (i_fpr_we && i_fpr_single && !sp_zexp && !sp_mexp ##1
       (i_fpr_src[0] == $past(i_fpr_dst) && !i_fpr_we))
      |=> (o_fpr_rdata[0][62:52] == ({3'h0, $past(sp_exp, 2)} + SP_TO_DP_BIAS))
          && (o_fpr_rdata[0][28:0] == 29'h00000000);
   endproperty
   a_fpr_single: assert property (p_fpr_single) else $error("single not widened");

   property p_fpr_rw;
      @(posedge i_mclk) disable iff (i_rst)
      (i_fpr_we && !i_fpr_single ##1 (i_fpr_src[2] == $past(i_fpr_dst) && !i_fpr_we))
      |=> (o_fpr_rdata[2] == $past(i_fpr_wdata, 2));
   endproperty
   a_fpr_rw: assert property (p_fpr_rw) else $error("fpr readback mismatch");

   property p_cmp_cr;
      @(posedge i_mclk) disable iff (i_rst)
      (i_wb_valid && i_wb_cmp)
      |=> (o_cr_we && o_cr_fld == $past(i_wb_crfld) && o_cr_data == $past(i_wb_cc)
           && o_float_status_control[16:19] == $past(i_wb_cc));
   endproperty
   a_cmp_cr: assert property (p_cmp_cr) else $error("compare did not reach cr");

   property p_wb_only;
      @(posedge i_mclk) disable iff (i_rst)
      (status_known && !i_wb_valid && i_fs_op == URF_OP_NONE)
      |=> (o_float_status_control == $past(o_float_status_control)) && !o_cr_we;
   endproperty
   a_wb_only: assert property (p_wb_only) else $error("status changed without writeback");

   property p_ctrl_hold;
      @(posedge i_mclk) disable iff (i_rst)
      (status_known && i_fs_op == URF_OP_NONE)
      |=> ((o_float_status_control & CTRL_MASK) == ($past(o_float_status_control) & CTRL_MASK));
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control bits moved");

   property p_wb_sets;
      @(posedge i_mclk) disable iff (i_rst)
      (i_wb_valid && !i_wb_cmp)
      |=> ((($past(i_wb_exc) & EXC_MASK) & ~o_float_status_control) == 32'h00000000)
          && (o_float_status_control[13:19] == {$past(i_wb_fr), $past(i_wb_fi), $past(i_wb_fprf)});
   endproperty
   a_wb_sets: assert property (p_wb_sets) else $error("writeback status lost");

   property p_sticky;
      @(posedge i_mclk) disable iff (i_rst)
      (status_known && i_fs_op == URF_OP_NONE)
      |=> ((($past(o_float_status_control) & ~o_float_status_control) & STICKY_MASK) == 32'h00000000);
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky bit dropped");

   property p_bit_clear;
      @(posedge i_mclk) disable iff (i_rst)
      (i_fs_op == URF_OP_CLR && !i_wb_valid && ((bit_mask & EXC_MASK) != 32'h00000000))
      |=> ((o_float_status_control & $past(bit_mask)) == 32'h00000000);
   endproperty
   a_bit_clear: assert property (p_bit_clear) else $error("bit clear ignored");

   property p_fx_new;
      @(posedge i_mclk) disable iff (i_rst)
      (i_wb_valid && ((i_wb_exc & EXC_MASK & ~o_float_status_control) != 32'h00000000)) |=> o_float_status_control[B_FX];
   endproperty
   a_fx_new: assert property (p_fx_new) else $error("summary not set on new flag");

   property p_fex_or;
      @(posedge i_mclk) disable iff (i_rst)
      $past(i_wb_valid || i_fs_op != URF_OP_NONE) |->
      o_float_status_control[B_FEX] == ((o_float_status_control[B_VX] & o_float_status_control[B_VE]) | (o_float_status_control[B_OX] & o_float_status_control[B_OE]) |
                         (o_float_status_control[B_UX] & o_float_status_control[B_UE]) | (o_float_status_control[B_ZX] & o_float_status_control[B_ZE]) |
                         (o_float_status_control[B_XX] & o_float_status_control[B_XE]));
   endproperty
   a_fex_or: assert property (p_fex_or) else $error("enabled summary wrong");

   property p_vx_or;
      @(posedge i_mclk) disable iff (i_rst)
      $past(i_wb_valid || i_fs_op != URF_OP_NONE) |->
      o_float_status_control[B_VX] == (|(o_float_status_control & VX_MASK));
   endproperty
   a_vx_or: assert property (p_vx_or) else $error("invalid summary wrong");

   property p_resv;
      @(posedge i_mclk) disable iff (i_rst)
      $past(i_wb_valid || i_fs_op != URF_OP_NONE) |-> ((o_float_status_control & RESV_MASK) == 32'h00000000);
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit nonzero");

   c_cmp: cover property (@(posedge i_mclk) disable iff (i_rst) i_wb_valid && i_wb_cmp);
   c_copy: cover property (@(posedge i_mclk) disable iff (i_rst) i_fs_op == URF_OP_COPY);
   c_fex: cover property (@(posedge i_mclk) disable iff (i_rst) !o_float_status_control[B_FEX] ##1 o_float_status_control[B_FEX]);
   c_race: cover property (@(posedge i_mclk) disable iff (i_rst) i_wb_valid && op_clr);

endmodule : urf_user_regs

// ---- test/urf_exec_model.sv ----
// execution unit model: float writeback and status move requests
`timescale 1ns/1ns
module urf_exec_model
   import urf_pkg::*;
(
   input  wire logic   i_mclk,
   output logic        o_wb_valid,
   output logic        o_wb_cmp,
   output logic [0:31] o_wb_exc,
   output logic        o_wb_fr,
   output logic [2:0]  o_wb_crfld,
   output logic [0:3]  o_wb_cc,
   output urf_fs_op_t  o_fs_op,
   output logic [2:0]  o_fs_fld,
   output logic [0:7]  o_fs_mask,
   output logic [0:31] o_fs_data,
   output logic [0:3]  o_fs_imm,
   output logic [4:0]  o_fs_bit
);
   // idle values are zero so a stale request can never be mistaken for a new one
   task automatic idle;
      o_wb_valid = 1'b0;
      o_wb_cmp   = 1'b0;
      o_wb_exc   = '0;
      o_wb_fr    = 1'b0;
      o_wb_crfld = '0;
      o_wb_cc    = '0;
      o_fs_op    = URF_OP_NONE;
      o_fs_fld   = '0;
      o_fs_mask  = '0;
      o_fs_data  = '0;
      o_fs_imm   = '0;
      o_fs_bit   = '0;
   endtask : idle

   initial begin
      idle();
   end

   // one-cycle strobe at the end of an operation's writeback stage
   task automatic wb(input logic cmp, input logic [0:31] exc, input logic fr,
                     input logic [2:0] fld, input logic [0:3] cc);
      @(posedge i_mclk);
      #1;
      o_wb_valid = 1'b1;
      o_wb_cmp   = cmp;
      o_wb_exc   = exc;
      o_wb_fr    = fr;
      o_wb_crfld = fld;
      o_wb_cc    = cc;
      @(posedge i_mclk);
      #1;
      idle();
   endtask : wb

   task automatic fs(input urf_fs_op_t op, input logic [2:0] fld, input logic [0:7] mask,
                     input logic [0:31] data, input logic [0:3] imm, input logic [4:0] b);
      @(posedge i_mclk);
      #1;
      o_fs_op   = op;
      o_fs_fld  = fld;
      o_fs_mask = mask;
      o_fs_data = data;
      o_fs_imm  = imm;
      o_fs_bit  = b;
      @(posedge i_mclk);
      #1;
      idle();
   endtask : fs
endmodule : urf_exec_model

// ---- test/test_urf_user_regs.sv ----
// self-checking bench for the user register file
`timescale 1ns/1ns
module test_urf_user_regs
   import urf_pkg::*;
;
   logic              clk;
   logic              rst;
   logic [ADDR_W-1:0] gsrc [GPR_RD];
   logic              gwe;
   logic [ADDR_W-1:0] gdst;
   logic [GPR_W-1:0]  gwd;
   logic [GPR_W-1:0]  grd [GPR_RD];
   logic [ADDR_W-1:0] fsrc [FPR_RD];
   logic              fwe;
   logic [ADDR_W-1:0] fdst;
   logic              fsgl;
   logic [FPR_W-1:0]  fwd;
   logic [FPR_W-1:0]  frd [FPR_RD];
   logic              wbv, wbc, wbfr;
   logic              wbfi;
   logic [0:4]        wbfprf;
   logic [0:31]       wbx, fsdata, float_status_control;
   logic [2:0]        wbfld, fsfld, crfld;
   logic [0:3]        wbcc, fsimm, crdata;
   urf_fs_op_t        fsop;
   logic [0:7]        fsmask;
   logic [4:0]        fsbit;
   logic              crwe;
   int                failures = 0;
   int                tests_run = 0;

   urf_exec_model exec_mdl (.i_mclk(clk), .o_wb_valid(wbv), .o_wb_cmp(wbc), .o_wb_exc(wbx),
      .o_wb_fr(wbfr), .o_wb_crfld(wbfld), .o_wb_cc(wbcc), .o_fs_op(fsop), .o_fs_fld(fsfld),
      .o_fs_mask(fsmask), .o_fs_data(fsdata), .o_fs_imm(fsimm), .o_fs_bit(fsbit));

   urf_user_regs dut (.i_mclk(clk), .i_rst(rst), .i_gpr_src(gsrc), .i_gpr_we(gwe),
      .i_gpr_dst(gdst), .i_gpr_wdata(gwd), .o_gpr_rdata(grd), .i_fpr_src(fsrc),
      .i_fpr_we(fwe), .i_fpr_dst(fdst), .i_fpr_single(fsgl), .i_fpr_wdata(fwd),
      .o_fpr_rdata(frd), .i_wb_valid(wbv), .i_wb_cmp(wbc), .i_wb_exc(wbx), .i_wb_fr(wbfr),
      .i_wb_fi(wbfi), .i_wb_fprf(wbfprf), .i_wb_crfld(wbfld), .i_wb_cc(wbcc),
      .i_fs_op(fsop), .i_fs_fld(fsfld), .i_fs_mask(fsmask), .i_fs_data(fsdata),
      .i_fs_imm(fsimm), .i_fs_bit(fsbit), .o_float_status_control(float_status_control), .o_cr_we(crwe),
      .o_cr_fld(crfld), .o_cr_data(crdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic gpr_wr(input logic [ADDR_W-1:0] a, input logic [GPR_W-1:0] d);
      @(posedge clk);
      #1;
      gwe  = 1'b1;
      gdst = a;
      gwd  = d;
      @(posedge clk);
      #1;
      gwe = 1'b0;
   endtask : gpr_wr

   task automatic fpr_wr(input logic [ADDR_W-1:0] a, input logic s, input logic [63:0] d);
      @(posedge clk);
      #1;
      fwe  = 1'b1;
      fdst = a;
      fsgl = s;
      fwd  = d;
      @(posedge clk);
      #1;
      fwe = 1'b0;
   endtask : fpr_wr

   // extreme entries both ways, read on both ports at once
   task automatic t_gpr;
      gpr_wr(5'h00, 32'hA5A50F0F);
      gpr_wr(5'h1F, 32'h5A5AF0F0);
      gsrc[0] = 5'h00;
      gsrc[1] = 5'h1F;
      @(posedge clk);
      #1;
      chk(grd[0], 32'hA5A50F0F, "gpr 0");
      chk(grd[1], 32'h5A5AF0F0, "gpr 31");
   endtask : t_gpr

   // singles land widened, denormal single flushes to signed zero
   task automatic t_fpr;
      fsrc[0] = 5'h01;
      fsrc[1] = 5'h02;
      fsrc[2] = 5'h1F;
      fpr_wr(5'h01, 1'b1, 64'h000000003F800000);
      fpr_wr(5'h02, 1'b1, 64'h0000000080000001);
      fpr_wr(5'h1F, 1'b0, 64'h0123456789ABCDEF);
      @(posedge clk);
      #1;
      chk(frd[0], 64'h3FF0000000000000, "fpr single one");
      chk(frd[1], 64'h8000000000000000, "fpr denormal");
      chk(frd[2], 64'h0123456789ABCDEF, "fpr double");
   endtask : t_fpr

   task automatic t_status;
      exec_mdl.fs(URF_OP_FIELD, 3'h0, 8'hFF, 32'h00000010, 4'h0, 5'h00);
      chk(float_status_control, 32'h00000010, "init");
      wbfi   = 1'b1;
      wbfprf = 5'h11;
      exec_mdl.wb(1'b0, 32'h04000000, 1'b1, 3'h0, 4'h0);
      chk(float_status_control, 32'hC4071010, "zero divide");
      wbfi   = 1'b0;
      wbfprf = 5'h00;
      exec_mdl.wb(1'b0, 32'h00000000, 1'b0, 3'h0, 4'h0);
      chk(float_status_control, 32'hC4000010, "clean op");
      exec_mdl.fs(URF_OP_CLR, 3'h0, 8'h00, 32'h0, 4'h0, 5'h05);
      chk(float_status_control, 32'h80000010, "clear bit");
   endtask : t_status

   // copy reads the field before clearing it; summary follows the flags
   task automatic t_vx;
      exec_mdl.wb(1'b0, 32'h01000000, 1'b0, 3'h0, 4'h0);
      chk(float_status_control, 32'hA1000010, "invalid op");
      exec_mdl.fs(URF_OP_COPY, 3'h0, 8'h00, 32'h0, 4'h0, 5'h00);
      chk(crwe, 1'b1, "copy strobe");
      chk(crdata, 4'hA, "copy data");
      chk(float_status_control, 32'h21000010, "after copy");
      exec_mdl.fs(URF_OP_CLR, 3'h0, 8'h00, 32'h0, 4'h0, 5'h07);
      chk(float_status_control, 32'h00000010, "invalid cleared");
      exec_mdl.fs(URF_OP_SET, 3'h0, 8'h00, 32'h0, 4'h0, 5'h03);
      chk(float_status_control, 32'h90000010, "set overflow");
      exec_mdl.fs(URF_OP_IMM, 3'h0, 8'h00, 32'h0, 4'h0, 5'h00);
      chk(float_status_control, 32'h00000010, "immediate");
      exec_mdl.fs(URF_OP_FIELD, 3'h0, 8'hFF, 32'h60000800, 4'h0, 5'h00);
      chk(float_status_control, 32'h00000000, "summary and reserved writes");
   endtask : t_vx

   task automatic t_cmp;
      exec_mdl.wb(1'b1, 32'h00000000, 1'b0, 3'h3, 4'hA);
      chk(crwe, 1'b1, "compare strobe");
      chk(crfld, 3'h3, "compare field");
      chk(crdata, 4'hA, "compare code");
      chk(float_status_control, 32'h0000A000, "compare status");
      @(posedge clk);
      #1;
      chk(crwe, 1'b0, "strobe ends");
   endtask : t_cmp

   // a mid-run reset must leave every register set untouched
   task automatic t_reset;
      rst = 1'b1;
      @(posedge clk);
      #1;
      chk(crfld, 3'h0, "cr field in reset");
      rst = 1'b0;
      @(posedge clk);
      #1;
      chk(float_status_control, 32'h0000A000, "status kept");
      chk(grd[1], 32'h5A5AF0F0, "gpr kept");
      chk(frd[2], 64'h0123456789ABCDEF, "fpr kept");
   endtask : t_reset

   initial begin
      #20000;
      failures++;
      finish_test();
   end

   initial begin
      rst  = 1'b1;
      gsrc = '{default: '0};
      fsrc = '{default: '0};
      gwe  = 1'b0;
      gdst = '0;
      gwd  = '0;
      fwe  = 1'b0;
      fdst = '0;
      fsgl = 1'b0;
      fwd  = '0;
      wbfi   = 1'b0;
      wbfprf = 5'h00;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      t_gpr();
      t_fpr();
      t_status();
      t_vx();
      t_cmp();
      t_reset();
      finish_test();
   end
endmodule : test_urf_user_regs
